//--- hdl/urxsf_break_detect.sv
/*
 * break detector: after a missing first stop bit, counts bit times
 * with the line low and pulses once when the count reaches ten.
 * assumes bitTick marks one bit time and rxLine is already synchronised.
 */
`timescale 1ns/1ns
module urxsf_break_detect (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic clear,
	input  wire logic rxLine,
	input  wire logic bitTick,
	input  wire logic stopMissing,
	output logic      breakSeen
);
	urxsf_pkg::urxsf_brk_t s;
	urxsf_pkg::urxsf_brk_t next_s;

	always_comb begin
		next_s      = s;
		next_s.seen = 1'b0;
		if (clear) begin
			next_s.armed   = 1'b0;
			next_s.lowBits = 4'h0;
		end else if (stopMissing) begin
			next_s.armed   = 1'b1;
			next_s.lowBits = 4'h0;
		end else if (s.armed && bitTick) begin
			if (rxLine) begin
				// a high bit ends the low run, no break
				next_s.armed = 1'b0;
			end else if (s.lowBits == urxsf_pkg::BREAK_BITS - 4'h1) begin
				next_s.armed = 1'b0;
				next_s.seen  = 1'b1;
			end else begin
				next_s.lowBits = s.lowBits + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign breakSeen = s.seen;
endmodule // urxsf_break_detect

//--- hdl/urxsf_pkg.sv
/*
 * constants and types of the receive-status and interrupt-flag block:
 * register indices, field positions, reset values, counts and the
 * packed state records of its three modules.
 * assumes APB with 32-bit data; byte address is four times the index.
 */
package urxsf_pkg;

	// ****************************************************************
	// bus geometry and register indices
	// ****************************************************************
	localparam int          ADDR_W       = 17;
	localparam int          IDX_W        = 15;
	localparam logic [14:0] IDX_CTL1     = 15'h7051;
	localparam logic [14:0] IDX_CTL2     = 15'h7054;
	localparam logic [14:0] IDX_STATUS   = 15'h7055;
	localparam logic [14:0] IDX_RXEMU    = 15'h7056;
	localparam logic [14:0] IDX_RXBUF    = 15'h7057;
	localparam logic [14:0] IDX_TXBUF    = 15'h7059;
	localparam logic [14:0] IDX_EVSTAT   = 15'h7060;
	localparam logic [14:0] IDX_EVMASK   = 15'h7061;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTL1_ERR_IE  = 6;
	localparam int CTL1_RUN     = 5;
	localparam int CTL2_TX_RDY  = 7;
	localparam int CTL2_TX_EMP  = 6;
	localparam int CTL2_RXBK_IE = 1;
	localparam int CTL2_TX_IE   = 0;
	localparam int ST_ERR       = 7;
	localparam int ST_RDY       = 6;
	localparam int ST_BRK       = 5;
	localparam int ST_FRM       = 4;
	localparam int ST_OE        = 3;
	localparam int ST_PAR       = 2;
	localparam int ST_WAKE      = 1;
	localparam int EV_RX        = 0;
	localparam int EV_BRK       = 1;
	localparam int EV_ERR       = 2;
	localparam int EV_TX        = 3;
	localparam int EV_W         = 4;

	// ****************************************************************
	// reset values and counts
	// ****************************************************************
	localparam logic [7:0]  RST_STATUS   = 8'h00;
	localparam logic [3:0]  RST_EVMASK   = 4'h0;
	localparam logic [3:0]  BREAK_BITS   = 4'ha;

	// ****************************************************************
	// carriers and state records
	// ****************************************************************
	typedef struct packed {
		logic       framingErr;
		logic       parityErr;
		logic       wake;
		logic [7:0] data;
	} urxsf_rx_char_t;

	typedef struct packed {
		logic meta;
		logic stable;
	} urxsf_sync_t;

	typedef struct packed {
		logic       armed;
		logic [3:0] lowBits;
		logic       seen;
	} urxsf_brk_t;

	typedef struct packed {
		logic             errIe;
		logic             running;
		logic             rxBrkIe;
		logic             txIe;
		logic             rxReady;
		logic             brk;
		logic             frmErr;
		logic             oe;
		logic             parErr;
		logic             wake;
		logic             txReady;
		logic [3:0]       evStat;
		logic [3:0]       evMask;
		logic [7:0]       txData;
		logic             txLoad;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             rxIrq;
		logic             txIrq;
		logic             errIrq;
		logic             irq;
	} urxsf_state_t;

endpackage

//--- hdl/urxsf_status_irq.sv
/*
 * receive-status flags, control enables and interrupt requests of an
 * asynchronous serial port, with an APB register slave.
 * assumes receiver and transmitter logic on the same clock deliver
 * one-cycle pulses; the serial line pin is asynchronous.
 */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
module urxsf_status_irq (
	input  wire logic                           clk,
	input  wire logic                           arst_n,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [urxsf_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                    pwdata,
	output logic                                pready,
	output logic [31:0]                         prdata,
	output logic                                pslverr,
	input  wire logic                           charXfer,
	input  wire urxsf_pkg::urxsf_rx_char_t      rxChar,
	input  wire logic                           rxLine,
	input  wire logic                           bitTick,
	input  wire logic                           stopMissing,
	input  wire logic                           txTaken,
	input  wire logic                           txShiftIdle,
	output logic [7:0]                          txData,
	output logic                                txLoad,
	output logic                                portSoftReset_n,
	output logic                                rxIrq,
	output logic                                txIrq,
	output logic                                errIrq,
	output logic                                irq
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic regHit(
		input logic [urxsf_pkg::ADDR_W-1:0] addr,
		input logic [urxsf_pkg::IDX_W-1:0]  idx
	);
		regHit = (addr == {idx, 2'b00});
	endfunction

	function automatic logic errSum(input urxsf_pkg::urxsf_state_t v);
		errSum = v.brk | v.frmErr | v.oe | v.parErr;
	endfunction

	urxsf_pkg::urxsf_state_t s;
	urxsf_pkg::urxsf_state_t next_s;
	logic                    lineSync;
	logic                    breakSeen;
	logic                    setup;
	logic                    access;
	logic                    rdRx;
	logic                    rdEv;
	logic                    wrTx;
	logic [3:0]              ev;

	urxsf_sync u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.async  (rxLine),
		.synced (lineSync)
	);

	urxsf_break_detect u_brk (
		.clk         (clk),
		.arst_n      (arst_n),
		.clear       (!s.running),
		.rxLine      (lineSync),
		.bitTick     (bitTick),
		.stopMissing (stopMissing),
		.breakSeen   (breakSeen)
	);

	// ****************************************************************
	// bus phases
	// ****************************************************************
	// pready is raised for the access cycle only, so no wait states
	assign setup  = psel && !penable;
	assign access = psel && penable && s.pready;
	assign rdRx   = access && !pwrite &&
		(regHit(paddr, urxsf_pkg::IDX_RXBUF));
	assign rdEv   = access && !pwrite && regHit(paddr, urxsf_pkg::IDX_EVSTAT);
	assign wrTx   = access && pwrite && regHit(paddr, urxsf_pkg::IDX_TXBUF);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_s         = s;
		next_s.txLoad  = 1'b0;
		next_s.pready  = 1'b0;
		next_s.pslverr = 1'b0;
		ev             = 4'h0;

		// read data is latched at setup and held through the access
		if (setup) begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h0000_0000;
			if (regHit(paddr, urxsf_pkg::IDX_CTL1)) begin
				next_s.prdata[urxsf_pkg::CTL1_ERR_IE] = s.errIe;
				next_s.prdata[urxsf_pkg::CTL1_RUN]    = s.running;
			end else if (regHit(paddr, urxsf_pkg::IDX_CTL2)) begin
				next_s.prdata[urxsf_pkg::CTL2_TX_RDY]  = s.txReady;
				next_s.prdata[urxsf_pkg::CTL2_TX_EMP]  = s.txReady && txShiftIdle;
				next_s.prdata[urxsf_pkg::CTL2_RXBK_IE] = s.rxBrkIe;
				next_s.prdata[urxsf_pkg::CTL2_TX_IE]   = s.txIe;
			end else if (regHit(paddr, urxsf_pkg::IDX_STATUS)) begin
				next_s.prdata[urxsf_pkg::ST_ERR]  = errSum(s);
				next_s.prdata[urxsf_pkg::ST_RDY]  = s.rxReady;
				next_s.prdata[urxsf_pkg::ST_BRK]  = s.brk;
				next_s.prdata[urxsf_pkg::ST_FRM]  = s.frmErr;
				next_s.prdata[urxsf_pkg::ST_OE]   = s.oe;
				next_s.prdata[urxsf_pkg::ST_PAR]  = s.parErr;
				next_s.prdata[urxsf_pkg::ST_WAKE] = s.wake;
			end else if (regHit(paddr, urxsf_pkg::IDX_RXBUF) ||
				regHit(paddr, urxsf_pkg::IDX_RXEMU)) begin
				next_s.prdata[7:0] = rxChar.data;
			end else if (regHit(paddr, urxsf_pkg::IDX_EVSTAT)) begin
				next_s.prdata[3:0] = s.evStat;
			end else if (regHit(paddr, urxsf_pkg::IDX_EVMASK)) begin
				next_s.prdata[3:0] = s.evMask;
			end else if (!regHit(paddr, urxsf_pkg::IDX_TXBUF)) begin
				next_s.pslverr = 1'b1;
			end
		end

		if (access && pwrite) begin
			if (regHit(paddr, urxsf_pkg::IDX_CTL1)) begin
				next_s.errIe   = pwdata[urxsf_pkg::CTL1_ERR_IE];
				next_s.running = pwdata[urxsf_pkg::CTL1_RUN];
			end
			if (regHit(paddr, urxsf_pkg::IDX_CTL2)) begin
				next_s.rxBrkIe = pwdata[urxsf_pkg::CTL2_RXBK_IE];
				next_s.txIe    = pwdata[urxsf_pkg::CTL2_TX_IE];
			end
			if (regHit(paddr, urxsf_pkg::IDX_EVMASK)) begin
				next_s.evMask = pwdata[3:0];
			end
			if (wrTx) begin
				next_s.txData = pwdata[7:0];
				next_s.txLoad = 1'b1;
			end
		end

		if (!s.running) begin
			next_s.rxReady = 1'b0;
			next_s.brk     = 1'b0;
			next_s.frmErr  = 1'b0;
			next_s.oe      = 1'b0;
			next_s.parErr  = 1'b0;
			next_s.wake    = 1'b0;
			next_s.txReady = 1'b1;
			next_s.txLoad  = 1'b0;
		end else begin
			next_s.rxReady = (s.rxReady && !rdRx) || charXfer;
			if (charXfer) begin
				next_s.frmErr = s.frmErr || rxChar.framingErr;
				next_s.parErr = s.parErr || rxChar.parityErr;
				next_s.wake = rxChar.wake;
				next_s.oe   = s.oe || (s.rxReady && !rdRx);
			end
			next_s.brk = s.brk || breakSeen;
			next_s.txReady = (s.txReady && !wrTx) || txTaken;
		end

		ev[urxsf_pkg::EV_RX]  = s.running && charXfer;
		ev[urxsf_pkg::EV_BRK] = s.running && breakSeen;
		ev[urxsf_pkg::EV_ERR] = errSum(next_s) && !errSum(s);
		ev[urxsf_pkg::EV_TX]  = s.running && txTaken;
		// only the bits actually returned are cleared, so a new event wins
		next_s.evStat = (s.evStat & ~(rdEv ? s.prdata[3:0] : 4'h0)) | ev;

		next_s.rxIrq  = (next_s.rxReady || next_s.brk) && next_s.rxBrkIe;
		next_s.txIrq  = next_s.txReady && next_s.txIe;
		next_s.errIrq = errSum(next_s) && next_s.errIe;
		next_s.irq    = |(next_s.evStat & next_s.evMask);
	end

	// port comes out of reset held; software starts it via control one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s         <= '0;
			s.txReady <= 1'b1;
			s.evMask  <= urxsf_pkg::RST_EVMASK;
		end else begin
			s <= next_s;
		end
	end

	assign pready          = s.pready;
	assign prdata          = s.prdata;
	assign pslverr         = s.pslverr;
	assign txData          = s.txData;
	assign txLoad          = s.txLoad;
	assign portSoftReset_n = s.running;
	assign rxIrq           = s.rxIrq;
	assign txIrq           = s.txIrq;
	assign errIrq          = s.errIrq;
	assign irq             = s.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_rx_irq;
		@(posedge clk) disable iff (!arst_n)
		s.running && charXfer && s.rxBrkIe && !(access && pwrite) |=> rxIrq;
	endproperty
	a_rx_irq: assert property (p_rx_irq)
		else $error("rx request missing after character");

	property p_rdy_unmasked;
		@(posedge clk) disable iff (!arst_n)
		s.running && charXfer && !s.rxBrkIe && !(access && pwrite) |=>
			s.rxReady && !rxIrq;
	endproperty
	a_rdy_unmasked: assert property (p_rdy_unmasked)
		else $error("char-ready not set while masked");

	property p_tx_irq;
		@(posedge clk) disable iff (!arst_n)
		s.running && txTaken && !(access && pwrite) |=>
			s.txReady && (txIrq == s.txIe);
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("tx request does not follow enable");

	property p_frm_set;
		@(posedge clk) disable iff (!arst_n)
		s.running && charXfer && rxChar.framingErr ##1 s.running |-> s.frmErr;
	endproperty
	a_frm_set: assert property (p_frm_set)
		else $error("framing error not flagged");

	property p_sum_read;
		@(posedge clk) disable iff (!arst_n)
		access && regHit(paddr, urxsf_pkg::IDX_STATUS) |->
			prdata[7] == (|prdata[5:2]) && prdata[0] == 1'b0 &&
			prdata[31:8] == 24'h000000;
	endproperty
	a_sum_read: assert property (p_sum_read)
		else $error("status readback summary or zero bits wrong");

	property p_err_irq;
		@(posedge clk) disable iff (!arst_n)
		s.errIe && !(access && pwrite) && s.running ##1 errSum(s) |-> errIrq;
	endproperty
	a_err_irq: assert property (p_err_irq)
		else $error("error request missing");

	property p_sum_sticky;
		@(posedge clk) disable iff (!arst_n)
		s.running && errSum(s) |=> errSum(s) || !$past(s.running, 1) ||
			!s.running;
	endproperty
	a_sum_sticky: assert property (p_sum_sticky)
		else $error("error summary cleared without reset");

	property p_rdy_clear;
		@(posedge clk) disable iff (!arst_n)
		rdRx && !charXfer |=> !s.rxReady[*2] or (!s.rxReady ##1 s.rxReady);
	endproperty
	a_rdy_clear: assert property (p_rdy_clear)
		else $error("char-ready survived buffer read");

	property p_tx_clear;
		@(posedge clk) disable iff (!arst_n)
		s.running && wrTx && !txTaken |=> !s.txReady && txLoad;
	endproperty
	a_tx_clear: assert property (p_tx_clear)
		else $error("tx-ready not cleared by write");

	property p_soft_rst;
		@(posedge clk) disable iff (!arst_n)
		!s.running |=> s.txReady && !s.rxReady && !errSum(s);
	endproperty
	a_soft_rst: assert property (p_soft_rst)
		else $error("soft reset left flags wrong");

	property p_break;
		@(posedge clk) disable iff (!arst_n)
		s.running && breakSeen |=> s.brk && errSum(s);
	endproperty
	a_break: assert property (p_break)
		else $error("break not flagged");

	property p_overrun;
		@(posedge clk) disable iff (!arst_n)
		s.running && charXfer && s.rxReady && !rdRx |=> s.oe;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");

	property p_level;
		@(posedge clk) disable iff (!arst_n)
		s.running && rxIrq && s.rxBrkIe && s.brk && !(access && pwrite) |=>
			rxIrq;
	endproperty
	a_level: assert property (p_level)
		else $error("rx request dropped while source set");

	property p_update;
		@(posedge clk) disable iff (!arst_n)
		s.running && charXfer |=> s.wake == $past(rxChar.wake);
	endproperty
	a_update: assert property (p_update)
		else $error("wake flag not updated on character");

	property p_rdy8;
		@(posedge clk) disable iff (!arst_n)
		s.running && charXfer && s.rxBrkIe && !(access && pwrite) |=>
			s.rxReady && rxIrq;
	endproperty
	a_rdy8: assert property (p_rdy8)
		else $error("char-ready set without request");
endmodule // urxsf_status_irq

//--- hdl/urxsf_sync.sv
/*
 * two-stage synchroniser for one level from outside the clock domain.
 * assumes the input may change at any time; only stable is read.
 */
`timescale 1ns/1ns
module urxsf_sync (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic async,
	output logic      synced
);
	urxsf_pkg::urxsf_sync_t s;
	urxsf_pkg::urxsf_sync_t next_s;

	always_comb begin
		next_s.meta   = async;
		next_s.stable = s.meta;
	end

	// reset to idle-high, the quiet level of a serial line
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= 2'b11;
		end else begin
			s <= next_s;
		end
	end

	assign synced = s.stable;
endmodule // urxsf_sync

//--- tb/tb_urxsf_status_irq.sv
/*
 * self-checking bench of the status and interrupt block over APB.
 * assumes the far-side model for receiver and transmitter events.
 */
`timescale 1ns/1ns
module tb_urxsf_status_irq;
	localparam logic [16:0] A_CTL1 = {urxsf_pkg::IDX_CTL1, 2'b00};
	localparam logic [16:0] A_CTL2 = {urxsf_pkg::IDX_CTL2, 2'b00};
	localparam logic [16:0] A_ST   = {urxsf_pkg::IDX_STATUS, 2'b00};
	localparam logic [16:0] A_EMU  = {urxsf_pkg::IDX_RXEMU, 2'b00};
	localparam logic [16:0] A_RXB  = {urxsf_pkg::IDX_RXBUF, 2'b00};
	localparam logic [16:0] A_TXB  = {urxsf_pkg::IDX_TXBUF, 2'b00};
	localparam logic [16:0] A_EVS  = {urxsf_pkg::IDX_EVSTAT, 2'b00};
	localparam logic [16:0] A_EVM  = {urxsf_pkg::IDX_EVMASK, 2'b00};
	localparam logic [16:0] A_BAD  = 17'h1c1f0;

	logic                      clk, arst_n, psel, penable, pwrite;
	logic [16:0]               paddr;
	logic [31:0]               pwdata, prdata, rd;
	logic                      pready, pslverr, err, charXfer, rxLine;
	urxsf_pkg::urxsf_rx_char_t rxChar;
	logic                      bitTick, stopMissing, txTaken, txShiftIdle;
	logic [7:0]                txData;
	logic                      txLoad, portSoftReset_n;
	logic                      rxIrq, txIrq, errIrq, irq;
	int                        n_errors, tests_run, cycles;

	urxsf_status_irq dut (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.charXfer(charXfer), .rxChar(rxChar), .rxLine(rxLine),
		.bitTick(bitTick), .stopMissing(stopMissing), .txTaken(txTaken),
		.txShiftIdle(txShiftIdle), .txData(txData), .txLoad(txLoad),
		.portSoftReset_n(portSoftReset_n), .rxIrq(rxIrq), .txIrq(txIrq),
		.errIrq(errIrq), .irq(irq));

	urxsf_far_side fs (.clk(clk), .charXfer(charXfer), .rxChar(rxChar),
		.rxLine(rxLine), .bitTick(bitTick), .stopMissing(stopMissing),
		.txTaken(txTaken), .txShiftIdle(txShiftIdle));

	// ****************************************************************
	// clock, timeout and shared tasks
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// whole run is a few hundred cycles; ceiling leaves ample margin
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic isWr, input logic [16:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= isWr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// no cycle limit here; a missing pready is ended only by the bench timeout
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_reg(input logic [16:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [16:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_word(rd, exp);
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
	endtask

	task automatic soft_reset();
		wr_reg(A_CTL1, 32'h0);
		wr_reg(A_CTL1, 32'h20);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rd_chk(A_ST, 32'h0);
		rd_chk(A_CTL2, 32'hc0);
		chk_bit(txIrq, 1'b0);
		chk_bit(portSoftReset_n, 1'b0);
		wr_reg(A_CTL1, 32'h20);
		wr_reg(A_CTL2, 32'h1);
		settle();
		chk_bit(txIrq, 1'b1);
		chk_bit(portSoftReset_n, 1'b1);
		wr_reg(A_CTL2, 32'h0);
		settle();
		chk_bit(txIrq, 1'b0);
		rd_chk(A_CTL2, 32'hc0);
		wr_reg(A_TXB, 32'ha5);
		@(posedge clk);
		chk_bit(txLoad, 1'b1);
		settle();
		chk_word({24'h0, txData}, 32'ha5);
		rd_chk(A_CTL2, 32'h0);
		fs.take_tx();
		settle();
		rd_chk(A_CTL2, 32'hc0);
		rd_chk(A_EVS, 32'h8);
		fs.set_shift_idle(1'b0);
		rd_chk(A_CTL2, 32'h80);
		fs.set_shift_idle(1'b1);
		// character with its request masked
		fs.put_char(1'b0, 1'b0, 1'b0, 8'h5a);
		settle();
		rd_chk(A_ST, 32'h40);
		chk_bit(rxIrq, 1'b0);
		wr_reg(A_CTL2, 32'h2);
		settle();
		chk_bit(rxIrq, 1'b1);
		rd_chk(A_EMU, 32'h5a);
		rd_chk(A_ST, 32'h40);
		rd_chk(A_RXB, 32'h5a);
		settle();
		chk_bit(rxIrq, 1'b0);
		rd_chk(A_ST, 32'h0);
		// overrun, summary stays after buffer read
		wr_reg(A_CTL1, 32'h60);
		fs.put_char(1'b0, 1'b0, 1'b0, 8'h11);
		fs.put_char(1'b0, 1'b0, 1'b0, 8'h33);
		settle();
		chk_bit(errIrq, 1'b1);
		wr_reg(A_ST, 32'h0);
		rd_chk(A_ST, 32'hc8);
		rd_chk(A_RXB, 32'h33);
		rd_chk(A_ST, 32'h88);
		wr_reg(A_CTL1, 32'h20);
		settle();
		chk_bit(errIrq, 1'b0);
		soft_reset();
		rd_chk(A_ST, 32'h0);
		fs.put_char(1'b1, 1'b1, 1'b1, 8'h7e);
		settle();
		rd_chk(A_ST, 32'hd6);
		soft_reset();
		wr_reg(A_CTL2, 32'h2);
		// break needs the tenth low bit time
		fs.start_break();
		fs.ticks(9);
		settle();
		rd_chk(A_ST, 32'h0);
		fs.ticks(1);
		settle();
		rd_chk(A_ST, 32'ha0);
		chk_bit(rxIrq, 1'b1);
		fs.end_break();
		soft_reset();
		// summary interrupt: raise, clear on read, mask
		apb(1'b0, A_EVS, 32'h0);
		wr_reg(A_EVM, 32'h1);
		fs.put_char(1'b0, 1'b0, 1'b0, 8'h42);
		settle();
		chk_bit(irq, 1'b1);
		rd_chk(A_EVS, 32'h1);
		settle();
		chk_bit(irq, 1'b0);
		wr_reg(A_EVM, 32'h0);
		fs.put_char(1'b0, 1'b0, 1'b0, 8'h43);
		settle();
		chk_bit(irq, 1'b0);
		rd_chk(A_EVS, 32'h5);
		apb(1'b0, A_BAD, 32'h0);
		chk_bit(err, 1'b1);
		apb(1'b0, A_ST, 32'h0);
		chk_bit(err, 1'b0);
		give_verdict();
	end
endmodule // tb_urxsf_status_irq

//--- tb/urxsf_far_side.sv
/*
 * model of the receiver and transmitter that sit beside the status block:
 * hands over characters, makes breaks and frees the transmit buffer.
 * assumes the caller enters each task just after a rising clock edge.
 */
`timescale 1ns/1ns
module urxsf_far_side (
	input  wire logic                  clk,
	output logic                       charXfer,
	output urxsf_pkg::urxsf_rx_char_t  rxChar,
	output logic                       rxLine,
	output logic                       bitTick,
	output logic                       stopMissing,
	output logic                       txTaken,
	output logic                       txShiftIdle
);
	// ****************************************************************
	// idle levels and transfer tasks
	// ****************************************************************
	// line idles high, as the pin has a pull-up
	initial begin
		charXfer = 1'b0;
		rxChar = '0;
		rxLine = 1'b1;
		bitTick = 1'b0;
		stopMissing = 1'b0;
		txTaken = 1'b0;
		txShiftIdle = 1'b1;
	end

	// whole character moved in
	// character stays on rxChar, like the held receive buffer
	task automatic put_char(input logic frErr, input logic parErr,
		input logic wk, input logic [7:0] d);
		@(posedge clk);
		charXfer <= 1'b1;
		rxChar <= {frErr, parErr, wk, d};
		@(posedge clk);
		charXfer <= 1'b0;
	endtask

	task automatic start_break();
		@(posedge clk);
		stopMissing <= 1'b1;
		rxLine <= 1'b0;
		@(posedge clk);
		stopMissing <= 1'b0;
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk);
			bitTick <= 1'b1;
			@(posedge clk);
			bitTick <= 1'b0;
		end
	endtask

	task automatic end_break();
		@(posedge clk);
		rxLine <= 1'b1;
	endtask

	// shifter busy or idle, seen in the tx-empty readback
	task automatic set_shift_idle(input logic v);
		@(posedge clk);
		txShiftIdle <= v;
	endtask

	task automatic take_tx();
		@(posedge clk);
		txTaken <= 1'b1;
		@(posedge clk);
		txTaken <= 1'b0;
	endtask
endmodule // urxsf_far_side
